//--- spi_params.svh
`ifndef SPI_PARAMS_SVH
`define SPI_PARAMS_SVH

// ==========================================================
// Buffer RAM
`define RAM_ENTRIES     256
`define IDX_W           8
`define FIELD_W         16
`define FLD_TX          2'h0
`define FLD_RX          2'h1
`define FLD_CTRL        2'h2
`define FLD_STAT        2'h3
`define CTRL_LEN_MSB    3
`define CTRL_LEN_LSB    0
`define CTRL_KEEP_BIT   4
`define STAT_DONE_BIT   0
`define STAT_KEEP_BIT   1
`define FIFO_DEPTH      4

// ==========================================================
// Control, format and delay words
`define GCR_W           8
`define GCR_CTRL_BIT    0
`define FMT_W           18
`define FMT_PS_MSB      15
`define FMT_PS_LSB      8
`define FMT_PHASE_BIT   16
`define FMT_POL_BIT     17
`define DLY_W           16
`define DLY_T2C_MSB     7
`define DLY_T2C_LSB     0
`define DLY_C2T_MSB     15
`define DLY_C2T_LSB     8

// ==========================================================
// Timing
`define LEAD_EXTRA      9'h002
`define LEAD_EXTRA_KEEP 9'h003
`define LAG_EXTRA       9'h001
`define PS_ZERO_PERIOD  9'h002
`define MIN_LEN_M1      4'h1
`define MAX_SHIFT       4'hF
`define REF_PERIOD_NS   25
`define MIN_SCLK_NS     25
`define MIN_SCLK_CYC    ((`MIN_SCLK_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)

`endif

//--- spi_pkg.sv
`include "spi_params.svh"

package spi_pkg;

  typedef struct packed {
    logic [`FIELD_W-1:0] tx;
    logic [`FIELD_W-1:0] rx;
    logic [`FIELD_W-1:0] ctrl;
    logic [`FIELD_W-1:0] stat;
  } entry_t;

  typedef struct packed {
    logic [`IDX_W-1:0]   idx;
    logic [`FIELD_W-1:0] ctrl;
    logic [`FIELD_W-1:0] tx;
  } word_t;

  typedef enum logic [4:0] {
    E_IDLE = 5'h01,
    E_LEAD = 5'h02,
    E_LOW  = 5'h04,
    E_HIGH = 5'h08,
    E_LAG  = 5'h10
  } eng_t;

  typedef enum logic [2:0] {
    F_IDLE = 3'h1,
    F_READ = 3'h2,
    F_PUSH = 3'h4
  } fetch_t;

endpackage

//--- fifo_if.sv
interface fifo_if #(parameter int WIDTH = 40) ();
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo_side (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user_side (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

//--- word_fifo.sv
// DEPTH must be a power of two: pointers wrap by overflow
module word_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 4
) (
  input wire logic  ref_clk,
  input wire logic  reset_n,
  fifo_if.fifo_side q
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
  } fifo_st_t;

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  assign q.wr_ready = (st_q.cnt != (AW+1)'(DEPTH));
  assign q.rd_valid = (st_q.cnt != '0);
  assign q.rd_data  = st_q.mem[st_q.rd];

  always_comb begin
    st_d = st_q;
    push = q.wr_valid && q.wr_ready;
    pop  = q.rd_valid && q.rd_ready;
    if (push) begin
      st_d.mem[st_q.wr] = q.wr_data;
      st_d.wr           = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  a_fifo_full_refuse : assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_q.cnt == (AW+1)'(DEPTH) && !pop) |=> (st_q.cnt == (AW+1)'(DEPTH) && !q.wr_ready))
    else $error("fifo accepted a word while full");
endmodule

//--- entry_ram.sv
`include "spi_params.svh"

module entry_ram
  import spi_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic [`IDX_W-1:0]   sw_addr,
  input  wire logic [1:0]          sw_field,
  input  wire logic [`FIELD_W-1:0] sw_wdata,
  input  wire logic                sw_we,
  input  wire logic                sw_re,
  output logic      [`FIELD_W-1:0] sw_rdata,
  input  wire logic [`IDX_W-1:0]   eng_raddr,
  output logic      [`FIELD_W-1:0] eng_tx,
  output logic      [`FIELD_W-1:0] eng_ctrl,
  input  wire logic [`IDX_W-1:0]   eng_waddr,
  input  wire logic                eng_we,
  input  wire logic [`FIELD_W-1:0] eng_rx,
  input  wire logic [`FIELD_W-1:0] eng_stat
);
  typedef struct packed {
    logic [`FIELD_W-1:0] sw_rdata;
    logic [`FIELD_W-1:0] tx;
    logic [`FIELD_W-1:0] ctrl;
  } ram_st_t;

  entry_t  mem [`RAM_ENTRIES];  // [R1]
  ram_st_t st_q;
  ram_st_t st_d;
  entry_t  sw_ent;

  assign sw_rdata = st_q.sw_rdata;
  assign eng_tx   = st_q.tx;
  assign eng_ctrl = st_q.ctrl;

  always_comb begin
    st_d   = st_q;
    sw_ent = mem[sw_addr];
    st_d.tx   = mem[eng_raddr].tx;
    st_d.ctrl = mem[eng_raddr].ctrl;
    if (sw_re) begin
      case (sw_field)
        `FLD_TX:   st_d.sw_rdata = sw_ent.tx;
        `FLD_RX:   st_d.sw_rdata = sw_ent.rx;
        `FLD_CTRL: st_d.sw_rdata = sw_ent.ctrl;
        default:   st_d.sw_rdata = sw_ent.stat;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Engine result writes last so it wins a clash on rx or status
  always_ff @(posedge ref_clk) begin
    if (sw_we) begin
      case (sw_field)
        `FLD_TX:   mem[sw_addr].tx   <= sw_wdata;
        `FLD_RX:   mem[sw_addr].rx   <= sw_wdata;
        `FLD_CTRL: mem[sw_addr].ctrl <= sw_wdata;
        default:   mem[sw_addr].stat <= sw_wdata;
      endcase
    end
    if (eng_we) begin
      mem[eng_waddr].rx   <= eng_rx;    // [R15]
      mem[eng_waddr].stat <= eng_stat;  // [R15]
    end
  end
endmodule

//--- multibuffer_spi_controller.sv
// Behaviour
// [R1] Buffer RAM: 256 entries of four 16-bit fields
// [R2] RAM splits into groups of chosen entries
// [R3] Clock period prescale+1 cycles, two for zero
// [R4] Drive pins only when controller bit set
// [R5] Format bit 16 picks clock phase
// [R6] Format bit 17 picks idle level, active edge
// [R7] Select leads first edge by delay+2 cycles
// [R8] With select keep, lead is delay+3 cycles
// [R9] Select lags last edge: half period+delay+1
// [R10] Both delays come from the delay word
// [R11] Clock high and low halves each half period; odd periods make the active half one longer
// [R12] Output bit stable half period around edge
// [R13] Peripheral keeps input bit stable at edge
// [R14] Words of 2 to 16 bits, full duplex
// [R15] Received word and status back to entry
`include "spi_params.svh"

module multibuffer_spi_controller
  import spi_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic [`GCR_W-1:0]   global_control_register,
  input  wire logic [`FMT_W-1:0]   data_format_register,
  input  wire logic [`DLY_W-1:0]   select_delay_register,
  input  wire logic [`IDX_W-1:0]   group_first,
  input  wire logic [`IDX_W-1:0]   group_last,
  input  wire logic                group_start,
  output logic                     busy,
  output logic                     group_done,
  input  wire logic [`IDX_W-1:0]   ram_addr,
  input  wire logic [1:0]          ram_field,
  input  wire logic [`FIELD_W-1:0] ram_wdata,
  input  wire logic                ram_we,
  input  wire logic                ram_re,
  output logic      [`FIELD_W-1:0] ram_rdata,
  output logic                     serial_clock_pin,
  output logic                     serial_clock_oe,
  output logic                     controller_out_line,
  output logic                     controller_out_oe,
  input  wire logic                controller_in_line,
  output logic                     chip_select_n,
  output logic                     chip_select_oe
);
  // ==========================================================
  // State
  typedef struct packed {
    eng_t                eng;
    fetch_t              fet;
    logic [`IDX_W-1:0]   ptr;
    logic [`IDX_W-1:0]   last;
    logic [`IDX_W-1:0]   idx;
    logic [8:0]          cnt;
    logic [3:0]          bits_left;
    logic [3:0]          len_m1;
    logic [`FIELD_W-1:0] tx_sh;
    logic [`FIELD_W-1:0] rx_sh;
    logic [7:0]          ps;
    logic [7:0]          c2t;
    logic [7:0]          t2c;
    logic                pol;
    logic                pha;
    logic                keep;
    logic                sclk;
    logic                mosi;
    logic                cs_n;
    logic                oe;
    logic                rx_we;
    logic                busy;
    logic                done;
    logic                miso_s1;
    logic                miso_s2;
  } ctl_t;

  ctl_t                st;
  ctl_t                n;
  logic                en;
  logic [8:0]          period;
  logic [8:0]          lo_len;
  logic [8:0]          hi_len;
  logic [8:0]          lag_len;
  logic [3:0]          new_len;
  logic                new_keep;
  word_t               head;
  logic [`FIELD_W-1:0] eng_tx;
  logic [`FIELD_W-1:0] eng_ctrl;
  logic [`FIELD_W-1:0] stat_word;

  fifo_if #(.WIDTH($bits(word_t))) wq ();

  // ==========================================================
  // Submodules
  entry_ram u_ram (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .sw_addr   (ram_addr),
    .sw_field  (ram_field),
    .sw_wdata  (ram_wdata),
    .sw_we     (ram_we),
    .sw_re     (ram_re),
    .sw_rdata  (ram_rdata),
    .eng_raddr (st.ptr),
    .eng_tx    (eng_tx),
    .eng_ctrl  (eng_ctrl),
    .eng_waddr (st.idx),
    .eng_we    (st.rx_we),
    .eng_rx    (st.rx_sh),
    .eng_stat  (stat_word)
  );

  word_fifo #(.WIDTH($bits(word_t)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .q       (wq.fifo_side)
  );

  assign head       = word_t'(wq.rd_data);
  assign wq.wr_data = {st.ptr, eng_ctrl, eng_tx};
  assign wq.wr_valid = (st.fet == F_PUSH);
  assign stat_word  = `FIELD_W'({st.keep, 1'b1});  // [R15]

  assign serial_clock_pin    = st.sclk;
  assign controller_out_line = st.mosi;
  assign chip_select_n       = st.cs_n;
  assign serial_clock_oe     = st.oe;
  assign controller_out_oe   = st.oe;
  assign chip_select_oe      = st.oe;
  assign busy                = st.busy;
  assign group_done          = st.done;

  // ==========================================================
  // Next state
  always_comb begin
    n           = st;
    wq.rd_ready = 1'b0;
    en          = global_control_register[`GCR_CTRL_BIT];
    n.miso_s1   = controller_in_line;
    n.miso_s2   = st.miso_s1;
    n.oe        = en;  // [R4]
    n.rx_we     = 1'b0;
    n.done      = 1'b0;
    // Odd periods give the extra cycle to the active half
    period  = (st.ps == 8'h00) ? `PS_ZERO_PERIOD : {1'b0, st.ps} + 9'h001;  // [R3]
    lo_len  = {1'b0, period[8:1]};  // [R11]
    hi_len  = period - lo_len;  // [R11]
    lag_len = lo_len + {1'b0, st.t2c} + `LAG_EXTRA;  // [R9]
    new_len = head.ctrl[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
    new_keep = head.ctrl[`CTRL_KEEP_BIT];
    if (new_len == 4'h0) begin
      new_len = `MIN_LEN_M1;  // [R14]
    end

    // Fetch entries of the group into the word queue
    case (st.fet)
      F_IDLE: begin
        if (group_start && en && !st.busy) begin
          n.ptr  = group_first;  // [R2]
          n.last = group_last;  // [R2]
          n.busy = 1'b1;
          n.fet  = F_READ;
        end
      end
      F_READ: begin
        n.fet = F_PUSH;
      end
      F_PUSH: begin
        if (wq.wr_ready) begin
          if (st.ptr == st.last) begin
            n.fet = F_IDLE;
          end else begin
            n.ptr = st.ptr + 8'h01;  // [R2]
            n.fet = F_READ;
          end
        end
      end
      default: n.fet = F_IDLE;
    endcase

    // Serial engine
    case (st.eng)
      E_IDLE: begin
        if (st.cs_n) begin
          n.sclk = data_format_register[`FMT_POL_BIT];  // [R6]
        end
        if (en && wq.rd_valid) begin
          wq.rd_ready = 1'b1;
          n.ps   = data_format_register[`FMT_PS_MSB:`FMT_PS_LSB];  // [R3]
          n.pol  = data_format_register[`FMT_POL_BIT];  // [R6]
          n.pha  = data_format_register[`FMT_PHASE_BIT];  // [R5]
          n.c2t  = select_delay_register[`DLY_C2T_MSB:`DLY_C2T_LSB];  // [R10]
          n.t2c  = select_delay_register[`DLY_T2C_MSB:`DLY_T2C_LSB];  // [R10]
          n.idx  = head.idx;
          n.keep = new_keep;
          n.len_m1    = new_len;
          n.bits_left = new_len;
          n.tx_sh = head.tx << (`MAX_SHIFT - new_len);  // [R14]
          n.rx_sh = '0;
          n.sclk  = data_format_register[`FMT_POL_BIT];
          n.cs_n  = 1'b0;
          // Phase 0 shows the first bit with select
          if (!data_format_register[`FMT_PHASE_BIT]) begin
            n.mosi = n.tx_sh[`FIELD_W-1];  // [R5] [R12]
          end
          n.cnt = {1'b0, select_delay_register[`DLY_C2T_MSB:`DLY_C2T_LSB]}
                  + (new_keep ? `LEAD_EXTRA_KEEP : `LEAD_EXTRA);  // [R7] [R8]
          n.eng = E_LEAD;
        end else if (!st.cs_n && st.fet == F_IDLE) begin
          // Held select ends once the group has nothing left
          n.cnt = lag_len;  // [R9]
          n.eng = E_LAG;
        end
      end
      E_LEAD, E_LOW: begin
        if (st.cnt == 9'h001) begin
          n.sclk = ~st.pol;  // [R6] [R11]
          if (st.pha) begin
            n.mosi  = st.tx_sh[`FIELD_W-1];
            n.tx_sh = st.tx_sh << 1;
          end else begin
            n.rx_sh = {st.rx_sh[`FIELD_W-2:0], st.miso_s2};  // [R13] [R14]
          end
          n.cnt = hi_len;  // [R11]
          n.eng = E_HIGH;
        end else begin
          n.cnt = st.cnt - 9'h001;
        end
      end
      E_HIGH: begin
        if (st.cnt == 9'h001) begin
          n.sclk = st.pol;  // [R11]
          if (st.pha) begin
            n.rx_sh = {st.rx_sh[`FIELD_W-2:0], st.miso_s2};  // [R13] [R14]
          end
          if (st.bits_left == 4'h0) begin
            n.rx_we = 1'b1;  // [R15]
            if (st.keep) begin
              n.eng = E_IDLE;  // [R8]
            end else begin
              n.cnt = lag_len;  // [R9]
              n.eng = E_LAG;
            end
          end else begin
            if (!st.pha) begin
              n.tx_sh = st.tx_sh << 1;
              n.mosi  = st.tx_sh[`FIELD_W-2];  // [R12]
            end
            n.bits_left = st.bits_left - 4'h1;
            n.cnt = lo_len;  // [R11]
            n.eng = E_LOW;
          end
        end else begin
          n.cnt = st.cnt - 9'h001;
        end
      end
      E_LAG: begin
        if (st.cnt == 9'h001) begin
          n.cs_n = 1'b1;  // [R9]
          n.eng  = E_IDLE;
        end else begin
          n.cnt = st.cnt - 9'h001;
        end
      end
      default: n.eng = E_IDLE;
    endcase

    if (st.busy && st.fet == F_IDLE && st.eng == E_IDLE && !wq.rd_valid && st.cs_n && !st.rx_we) begin
      n.busy = 1'b0;
      n.done = 1'b1;
    end

    // Dropping the enable aborts the word; queued words stay
    if (!en) begin
      n.eng  = E_IDLE;
      n.fet  = F_IDLE;
      n.cs_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st      <= '0;
      st.eng  <= E_IDLE;
      st.fet  <= F_IDLE;
      st.cs_n <= 1'b1;
    end else begin
      st <= n;
    end
  end

  // ==========================================================
  // Checks
  logic [8:0] run_len_q;
  logic [8:0] lead_run_q;
  logic [8:0] lag_run_q;
  logic [8:0] half_prev_q;
  logic [4:0] edge_cnt_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_len_q  <= 9'h000;
      lead_run_q <= 9'h000;
      lag_run_q  <= 9'h000;
      half_prev_q <= 9'h000;
      edge_cnt_q <= 5'h00;
    end else begin
      run_len_q  <= (n.sclk != st.sclk) ? 9'h001 : run_len_q + 9'h001;
      lead_run_q <= (st.eng == E_LEAD) ? lead_run_q + 9'h001 : 9'h000;
      lag_run_q  <= (st.eng == E_LAG) ? lag_run_q + 9'h001 : 9'h000;
      half_prev_q <= (n.sclk != st.sclk) ? run_len_q : half_prev_q;
      if (n.eng == E_HIGH && st.eng != E_HIGH) begin
        edge_cnt_q <= (st.eng == E_LEAD) ? 5'h01 : edge_cnt_q + 5'h01;
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_active_half_len : assert property (  // [R11]
    (st.eng == E_LOW && $past(st.eng) == E_HIGH) |-> $past(run_len_q) == hi_len)
    else $error("active clock half has wrong length");

  a_idle_half_len : assert property (  // [R11]
    (st.eng == E_HIGH && $past(st.eng) == E_LOW) |-> ($past(run_len_q) == lo_len
      && $past(run_len_q) + hi_len == period))
    else $error("idle clock half has wrong length");

  a_period_floor : assert property (  // [R3]
    (st.eng == E_HIGH && $past(st.eng) == E_LOW) |-> ((half_prev_q + $past(half_prev_q))
      == ((st.ps == 8'h00) ? 9'h002 : {1'b0, st.ps} + 9'h001)))
    else $error("serial clock period off prescale");

  a_lead_time : assert property (  // [R7] [R8]
    (st.eng == E_HIGH && $past(st.eng) == E_LEAD) |->
      lead_run_q == {1'b0, st.c2t} + (st.keep ? 9'h003 : 9'h002) && !st.cs_n)
    else $error("select lead to first edge wrong");

  a_lag_time : assert property (  // [R9]
    (st.eng == E_IDLE && $past(st.eng) == E_LAG) |->
      (st.cs_n && lag_run_q == lo_len + {1'b0, st.t2c} + 9'h001))
    else $error("select lag after last edge wrong");

  a_pins_released : assert property (  // [R4]
    !global_control_register[`GCR_CTRL_BIT] |=> (!serial_clock_oe && !controller_out_oe
      && !chip_select_oe && chip_select_n))
    else $error("pins driven with controller bit clear");

  a_out_bit_hold : assert property (  // [R12]
    (!st.pha && st.eng == E_HIGH && $past(st.eng) == E_HIGH) |-> $stable(st.mosi))
    else $error("output bit moved during active half");

  a_clock_polarity : assert property (  // [R6]
    (st.eng != E_IDLE) |-> ((st.eng == E_HIGH) ? (st.sclk != st.pol) : (st.sclk == st.pol)))
    else $error("serial clock level wrong for polarity");

  a_word_bits : assert property (  // [R14]
    st.rx_we |-> (edge_cnt_q == {1'b0, st.len_m1} + 5'h01 && $past(st.bits_left) == 4'h0))
    else $error("word did not shift programmed length");

  a_rx_stored : assert property (  // [R15]
    (st.eng == E_HIGH && st.cnt == 9'h001 && st.bits_left == 4'h0) |=>
      (st.rx_we && $stable(st.idx) && stat_word[`STAT_DONE_BIT]))
    else $error("received word not written back");
endmodule

//--- spi_target_model.sv
// ==========================================================
// Peripheral on the far side of the serial link
module spi_target_model (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic        pol,
  input  wire logic [15:0] pattern,
  output logic             miso,
  output logic [31:0]      heard,
  output int               n_active
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh;
  initial begin
    miso = 1'b0;
    heard = 32'h0000_0000;
    n_active = 0;
    sh = 16'h0000;
  end
  always @(negedge cs_n) begin
    sh = pattern;
    miso = pattern[15];
  end
  // Undriven line: no pull, so show the inverse of the last bit
  always @(posedge cs_n) begin
    miso = ~miso;
  end
  always @(sclk) begin
    if (cs_n === 1'b0) begin
      if (sclk !== pol) begin
        heard = {heard[30:0], mosi};
        n_active++;
      end else begin
        sh = sh << 1;
        miso = sh[15];
      end
    end
  end
endmodule

//--- multibuffer_spi_controller_bench.sv
`include "spi_params.svh"
module multibuffer_spi_controller_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, reset_n, gs, we, re, sclk, so, miso, cs_n, busy, done, pol;
  logic        sck_oe, so_oe, cs_oe, sp, cp, mp;
  logic [7:0]  gcr, gf, gl, addr;
  logic [17:0] fmt;
  logic [15:0] dly, wd, rd, rdv;
  logic [1:0]  fld;
  logic [31:0] heard;
  int          n_act, miscompares, n_compared, t, t_cs, t_ld, t_tr, lead, gap, lag;
  int          nfall, nlead, bad_hi, bad_mosi, hi_c;
  int          ps_t[4] = '{0, 1, 5, 6};
  int          pol_t[4] = '{0, 1, 0, 1};
  int          c2t_t[4] = '{0, 3, 1, 1};
  int          t2c_t[4] = '{0, 2, 1, 3};
  int          k_t[4] = '{0, 1, 1, 0};
  int          f_t[4] = '{0, 255, 10, 20};
  int          lm0_t[4] = '{15, 0, 4, 2};
  int          lm1_t[4] = '{1, 7, 15, 3};

  assign pol = fmt[`FMT_POL_BIT];

  multibuffer_spi_controller dut (.ref_clk(ref_clk), .reset_n(reset_n), .global_control_register(gcr),
    .data_format_register(fmt), .select_delay_register(dly), .group_first(gf), .group_last(gl),
    .group_start(gs), .busy(busy), .group_done(done), .ram_addr(addr), .ram_field(fld), .ram_wdata(wd),
    .ram_we(we), .ram_re(re), .ram_rdata(rd), .serial_clock_pin(sclk), .serial_clock_oe(sck_oe),
    .controller_out_line(so), .controller_out_oe(so_oe), .controller_in_line(miso),
    .chip_select_n(cs_n), .chip_select_oe(cs_oe));

  spi_target_model model (.sclk(sclk), .cs_n(cs_n), .mosi(so), .pol(pol), .pattern(16'h9B2D),
    .miso(miso), .heard(heard), .n_active(n_act));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Link monitor, sampled where outputs have settled
  always @(negedge ref_clk) begin
    t++;
    if (cp === 1'b1 && cs_n === 1'b0) begin
      nfall++;
      t_cs = t;
    end
    if (cs_n === 1'b0 && sclk !== sp) begin
      if (sclk !== pol) begin
        nlead++;
        t_ld = t;
        if (nlead == 1) lead = t - t_cs;
        if (nlead == 2) gap = t - t_tr;
      end else begin
        if (t - t_ld != hi_c) bad_hi++;
        t_tr = t;
      end
    end
    // Data may move at a trailing edge or while idle, never around the active edge
    if (cs_n === 1'b0 && cp === 1'b0 && so !== mp && sclk !== pol) bad_mosi++;
    if (cp === 1'b0 && cs_n === 1'b1) lag = t - t_tr;
    sp = sclk;
    cp = cs_n;
    mp = so;
  end

  // ==========================================================
  // Access and compare tasks
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task check_n(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task ram_wr(input logic [7:0] a, input logic [1:0] f, input logic [15:0] d);
    @(negedge ref_clk);
    addr = a;
    fld = f;
    wd = d;
    we = 1'b1;
    @(negedge ref_clk);
    we = 1'b0;
  endtask

  task ram_rd(input logic [7:0] a, input logic [1:0] f, output logic [15:0] d);
    @(negedge ref_clk);
    addr = a;
    fld = f;
    re = 1'b1;
    @(negedge ref_clk);
    re = 1'b0;
    d = rd;
  endtask

  task end_sim;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // One two-word group per configuration row
  task run_group(input int i);
    int p, lo, l0, l1, a0, k;
    logic [7:0] f;
    logic [15:0] tx0, tx1, m0, m1, r1;
    logic [31:0] msk;
    f = 8'(f_t[i]);
    k = k_t[i];
    p = ps_t[i] == 0 ? 2 : ps_t[i] + 1;
    lo = p / 2;
    l0 = lm0_t[i] == 0 ? 2 : lm0_t[i] + 1;
    l1 = lm1_t[i] == 0 ? 2 : lm1_t[i] + 1;
    tx0 = 16'hC3A5 ^ 16'(i);
    tx1 = 16'h5E17;
    ram_wr(f, `FLD_TX, tx0);
    ram_wr(f, `FLD_CTRL, 16'(k * 16 + lm0_t[i]));
    ram_wr(f + 8'h01, `FLD_TX, tx1);
    ram_wr(f + 8'h01, `FLD_CTRL, 16'(lm1_t[i]));
    @(negedge ref_clk);
    fmt = {1'(pol_t[i]), 1'b0, 8'(ps_t[i]), 8'h00};
    dly = {8'(c2t_t[i]), 8'(t2c_t[i])};
    hi_c = p - lo;
    repeat (3) @(negedge ref_clk);
    nfall = 0;
    nlead = 0;
    bad_hi = 0;
    bad_mosi = 0;
    a0 = n_act;
    gf = f;
    gl = f + 8'h01;
    gs = 1'b1;
    @(negedge ref_clk);
    gs = 1'b0;
    check("busy", 1, busy);
    repeat (2000) begin
      @(negedge ref_clk);
      if (done === 1'b1) break;
    end
    check("group_done", 1, done);
    check_n("lead", c2t_t[i] + 2 + k, lead);
    check_n("idle half", lo, gap);
    check_n("active half errors", 0, bad_hi);
    check_n("lag", lo + t2c_t[i] + 1, lag);
    check_n("select falls", 2 - k, nfall);
    check_n("clock edges", l0 + l1, nlead);
    check_n("target edges", l0 + l1, n_act - a0);
    check_n("out moves at active edge", 0, bad_mosi);
    m0 = tx0 & 16'((1 << l0) - 1);
    m1 = tx1 & 16'((1 << l1) - 1);
    msk = 32'((64'h1 << (l0 + l1)) - 1);
    check("out bits", ((32'(m0) << l1) | 32'(m1)) & msk, heard & msk);
    ram_rd(f, `FLD_STAT, rdv);
    check("status first", 16'(k * 2 + 1), rdv);
    ram_rd(f + 8'h01, `FLD_STAT, rdv);
    check("status second", 16'h0001, rdv);
    // Two-flop input sync needs three cycles ahead of each active edge
    if (lo >= 3) begin
      r1 = k == 1 ? 16'(16'h9B2D << l0) : 16'h9B2D;
      ram_rd(f, `FLD_RX, rdv);
      check("rx first", 16'h9B2D >> (16 - l0), rdv);
      ram_rd(f + 8'h01, `FLD_RX, rdv);
      check("rx second", r1 >> (16 - l1), rdv);
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_sim;
  end

  initial begin
    reset_n = 1'b0;
    {gs, we, re} = 3'h0;
    gcr = 8'h00;
    fmt = 18'h00000;
    dly = 16'h0000;
    {gf, gl, addr} = 24'h000000;
    fld = 2'h0;
    wd = 16'h0000;
    repeat (3) @(negedge ref_clk);
    check("cs_n in reset", 1, cs_n);
    check("oe in reset", 0, {sck_oe, so_oe, cs_oe});
    reset_n = 1'b1;
    @(negedge ref_clk);
    gs = 1'b1;
    @(negedge ref_clk);
    gs = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("start while disabled", 0, busy);
    check("oe while disabled", 0, {sck_oe, so_oe, cs_oe});
    gcr = 8'h01;
    repeat (2) @(negedge ref_clk);
    check("oe enabled", 3'h7, {sck_oe, so_oe, cs_oe});
    ram_wr(8'hFF, `FLD_CTRL, 16'h1234);
    ram_wr(8'h00, `FLD_CTRL, 16'hABCD);
    ram_rd(8'hFF, `FLD_CTRL, rdv);
    check("ram entry 255", 16'h1234, rdv);
    ram_rd(8'h00, `FLD_CTRL, rdv);
    check("ram entry 0", 16'hABCD, rdv);
    for (int i = 0; i < 4; i++) begin
      run_group(i);
    end
    end_sim;
  end
endmodule
